// ---- verilog/pwmt_pkg.sv ----
// Package for the PWM timer channel block: register byte addresses,
// field widths, reset values and the carrier structs shared by ports.
// Assumes a single 200 MHz clock domain and synchronous reset.
package pwmt_pkg;

  // ----------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------
  localparam int unsigned PWMT_CNT_W  = 16;
  localparam int unsigned PWMT_DIV_W  = 7;
  localparam int unsigned PWMT_ADDR_W = 3;

  // ----------------------------------------------------------------
  // Byte register addresses, high and low halves of each pair
  // ----------------------------------------------------------------
  localparam logic [2:0] PWMT_A_CNT_H = 3'h0;
  localparam logic [2:0] PWMT_A_CNT_L = 3'h1;
  localparam logic [2:0] PWMT_A_MOD_H = 3'h2;
  localparam logic [2:0] PWMT_A_MOD_L = 3'h3;
  localparam logic [2:0] PWMT_A_CV_H  = 3'h4;
  localparam logic [2:0] PWMT_A_CV_L  = 3'h5;

  // ----------------------------------------------------------------
  // Reset values and codes
  // ----------------------------------------------------------------
  localparam logic [15:0] PWMT_CNT_RST  = 16'h0000;
  localparam logic [15:0] PWMT_MOD_RST  = 16'h0000;
  localparam logic [15:0] PWMT_CV_RST   = 16'h0000;
  localparam logic [6:0]  PWMT_DIV_RST  = 7'h00;
  localparam logic [7:0]  PWMT_RD_RST   = 8'h00;
  localparam logic [1:0]  PWMT_CSS_STOP = 2'h0;
  localparam logic [2:0]  PWMT_PS_DIV2  = 3'h1;
  localparam int unsigned PWMT_SIGN_BIT = 15;

  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic       en;
    logic [2:0] addr;
    logic [7:0] data;
  } pwmt_wr_t;

  typedef struct packed {
    logic       center_aligned;
    logic [1:0] clock_source_select;
    logic [2:0] prescale_select;
  } pwmt_cfg_t;

endpackage : pwmt_pkg

// ---- verilog/pwmt_core.sv ----
// PWM timer channel with center- and edge-aligned counting, modelling
// the silicon behaviour at duty-cycle boundaries and across restarts.
// Assumes byte writes and reads by software, all synchronous to ref_clk.
`timescale 1ns/1ps
`default_nettype none

module pwmt_core (
  // Clock and reset
  input  wire logic              ref_clk,
  input  wire logic              rst_n,
  // Configuration
  input  wire pwmt_pkg::pwmt_cfg_t cfg,
  // Register byte access
  input  wire pwmt_pkg::pwmt_wr_t  wr,
  input  wire logic [2:0]        rd_addr,
  output logic [7:0]             rd_data,
  // Status and channel output
  output logic [15:0]            counter_value,
  output logic                   count_down,
  output logic                   pwm_out
);
  import pwmt_pkg::*;

  logic [15:0] cnt_q;
  logic [15:0] cnt_d;
  logic        dir_q;
  logic        dir_d;
  logic [15:0] mod_q;
  logic [15:0] cv_q;
  logic [15:0] cvb_q;
  logic [6:0]  div_q;
  logic [6:0]  div_mask;
  logic        pwm_q;
  logic [7:0]  rd_q;
  logic        running;
  logic        tick;
  logic        clr;
  logic        per_start;
  logic [15:0] mod_m1;

  // ----------------------------------------------------------------
  // Prescaler
  // ----------------------------------------------------------------
  assign running  = cfg.clock_source_select != PWMT_CSS_STOP;
  assign div_mask = 7'((8'h01 << cfg.prescale_select) - 8'h01);
  // A tick when all selected divider bits are ones
  assign tick     = running && ((div_q & div_mask) == div_mask);
  assign clr      = wr.en && (wr.addr == PWMT_A_CNT_H ||
                              wr.addr == PWMT_A_CNT_L);

  // Divider only reset by device reset; it freezes while stopped so a
  // restart continues mid-count and the first tick may come early
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      div_q <= PWMT_DIV_RST;
    end else if (running) begin
      div_q <= div_q + 7'h01;
    end
  end

  // ----------------------------------------------------------------
  // Counter next state
  // ----------------------------------------------------------------
  assign mod_m1 = mod_q - 16'h0001;

  // Direction turns as the count arrives at a limit, so a stop at the
  // modulo leaves the down state pending across a clear
  always_comb begin
    cnt_d     = cnt_q;
    dir_d     = dir_q;
    per_start = 1'b0;
    if (cfg.center_aligned) begin
      if (!dir_q) begin
        cnt_d = cnt_q + 16'h0001;
        if (cnt_d == mod_q) begin
          dir_d     = 1'b1;
          per_start = 1'b1;
        end
      end else begin
        cnt_d = cnt_q - 16'h0001;
        if (cnt_d == 16'h0000) begin
          dir_d = 1'b0;
        end
      end
    end else begin
      dir_d = 1'b0;
      if (cnt_q == mod_q) begin
        cnt_d     = 16'h0000;
        per_start = 1'b1;
      end else begin
        cnt_d = cnt_q + 16'h0001;
      end
    end
  end

  // Counter and direction; a clear wins over a tick but keeps direction
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      cnt_q <= PWMT_CNT_RST;
      dir_q <= 1'b0;
    end else if (clr) begin
      cnt_q <= 16'h0000;
    end else if (tick) begin
      cnt_q <= cnt_d;
      dir_q <= dir_d;
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  // Byte halves update independently; software orders its writes
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      mod_q <= PWMT_MOD_RST;
      cv_q  <= PWMT_CV_RST;
    end else if (wr.en) begin
      unique case (wr.addr)
        PWMT_A_MOD_H: mod_q[15:8] <= wr.data;
        PWMT_A_MOD_L: mod_q[7:0]  <= wr.data;
        PWMT_A_CV_H:  cv_q[15:8]  <= wr.data;
        PWMT_A_CV_L:  cv_q[7:0]   <= wr.data;
        default: ;
      endcase
    end
  end

  // Registered read port
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      rd_q <= PWMT_RD_RST;
    end else begin
      unique case (rd_addr)
        PWMT_A_CNT_H: rd_q <= cnt_q[15:8];
        PWMT_A_CNT_L: rd_q <= cnt_q[7:0];
        PWMT_A_MOD_H: rd_q <= mod_q[15:8];
        PWMT_A_MOD_L: rd_q <= mod_q[7:0];
        PWMT_A_CV_H:  rd_q <= cv_q[15:8];
        PWMT_A_CV_L:  rd_q <= cv_q[7:0];
        default:      rd_q <= PWMT_RD_RST;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Channel output
  // ----------------------------------------------------------------
  logic cvb_neg;
  logic cvb_edge;
  logic cvb_dead;
  logic cv_neg;
  logic cv_zero;

  assign cvb_neg  = cvb_q[PWMT_SIGN_BIT];
  assign cvb_edge = (cvb_q == mod_q) || (cvb_q == mod_m1);
  assign cvb_dead = cvb_neg || cvb_edge;
  assign cv_neg   = cv_q[PWMT_SIGN_BIT];
  assign cv_zero  = cv_q == 16'h0000;

  // Buffered value is taken at each period start; in center mode the live
  // value still steers the zero cases, which is what makes them misbehave
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      cvb_q <= PWMT_CV_RST;
      pwm_q <= 1'b0;
    end else if (tick && !clr) begin
      if (cfg.center_aligned) begin
        if (per_start) begin
          cvb_q <= cv_q;
          if (cv_neg || cv_zero || cv_q == mod_q || cv_q == mod_m1) begin
            pwm_q <= 1'b0;
          end
        end else if (dir_q && !cvb_dead && cvb_q != 16'h0000 &&
                     cnt_q == cvb_q) begin
          pwm_q <= 1'b1;
        end else if (dir_q && !cvb_dead && cvb_q == 16'h0000 &&
                     cnt_d == 16'h0000 && !cv_zero && !cv_neg) begin
          // A zero buffer never matches going down, since the count is
          // already turned up at zero; the live value sets it on arrival
          pwm_q <= 1'b1;
        end else if (!dir_q && !cvb_dead && cvb_q != 16'h0000 &&
                     cnt_q == cvb_q) begin
          if (!cv_zero) begin
            pwm_q <= 1'b0;
          end
        end
      end else begin
        if (per_start) begin
          // Set uses the old buffered value: update lands too late
          pwm_q <= !cvb_neg && (cvb_q != 16'h0000);
          cvb_q <= cv_q;
        end else if (cnt_q == cvb_q) begin
          pwm_q <= 1'b0;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign rd_data       = rd_q;
  assign counter_value = cnt_q;
  assign count_down    = dir_q;
  assign pwm_out       = pwm_q;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking ast_cb @(posedge ref_clk);
  endclocking
  default disable iff (!rst_n);

  sequence s_div2_steady;
    running && cfg.prescale_select == PWMT_PS_DIV2 && tick;
  endsequence

  sequence s_stop_at_mod;
    cfg.center_aligned && !running && dir_q && cnt_q == mod_q;
  endsequence

  AST_PRESCALE_DIV2: assert property (
    s_div2_steady ##1 $stable(cfg.prescale_select) && running
    |-> !tick ##1 (tick || !running || $changed(cfg.prescale_select)))
    else $error("divide by two prescale ticks wrong");

  AST_COUNT_CLEAR: assert property (
    clr |=> cnt_q == 16'h0000)
    else $error("counter not cleared by write");

  AST_STOP_HOLDS: assert property (
    !running && !clr |=> $stable(cnt_q) && $stable(div_q))
    else $error("counter moved while stopped");

  AST_TURN_DOWN: assert property (
    cfg.center_aligned && tick && !clr && !dir_q &&
    cnt_q == mod_m1 && mod_q > 16'h0001
    |=> dir_q && cnt_q == mod_q)
    else $error("direction did not turn at modulo");

  AST_CLEAR_KEEPS_DIR: assert property (
    s_stop_at_mod ##1 clr ##[1:8] (tick && !clr && cnt_q == 16'h0000)
    |=> dir_q && cnt_q == 16'hFFFF)
    else $error("restart after clear did not wrap down");

  AST_NEG_OFF: assert property (
    tick && !clr && per_start &&
    (cfg.center_aligned ? cv_neg : cvb_neg) |=> !pwm_q)
    else $error("negative channel value gave output");

  AST_CA_BOUNDARY_OFF: assert property (
    cfg.center_aligned && tick && !clr && per_start &&
    (cv_q == mod_q || cv_q == mod_m1)
    |=> !pwm_q)
    else $error("boundary channel value gave output");

  AST_OUT_ON_EVENT: assert property (
    !(tick && !clr) |=> $stable(pwm_q))
    else $error("output changed without a count event");

  AST_EDGE_ZERO_DELAY: assert property (
    !cfg.center_aligned && tick && !clr && per_start &&
    cvb_q == 16'h0000
    |=> !pwm_q)
    else $error("edge mode zero update took effect early");

  AST_CA_ZERO_SET: assert property (
    cfg.center_aligned && tick && !clr && dir_q && !per_start &&
    cnt_q == 16'h0001 && cvb_q == 16'h0000 && !cv_zero && !cv_neg &&
    !cvb_edge
    |=> pwm_q)
    else $error("zero to non-zero did not set output at zero");

  AST_CA_ZERO_HOLD: assert property (
    cfg.center_aligned && tick && !clr && !dir_q && !per_start &&
    cvb_q != 16'h0000 && cnt_q == cvb_q && cv_zero && pwm_q
    |=> pwm_q)
    else $error("zero update while up cut the pulse short");

  AST_CA_ZERO_PERIOD_OFF: assert property (
    cfg.center_aligned && tick && !clr && per_start && cv_zero
    |=> !pwm_q)
    else $error("zero channel value kept output at period start");

endmodule : pwmt_core

`default_nettype wire

// ---- tb/pwmt_tb.sv ----
// Self-checking bench for the PWM timer channel: count shape, prescale,
// stop and clear, and duty at the boundary values of the channel.
// Assumes pwmt_core and pwmt_pkg; the assertions live in the design.
`timescale 1ns/1ps
`default_nettype none
module tb;
  import pwmt_pkg::*;
  // ------------------------------------------------------------
  // Signals
  // ------------------------------------------------------------
  logic        ref_clk;
  logic        rst_n;
  pwmt_cfg_t   cfg;
  pwmt_wr_t    wr;
  logic [2:0]  rd_addr;
  logic [7:0]  rd_data;
  logic [15:0] counter_value;
  logic        count_down;
  logic        pwm_out;
  int          failures;
  int          samples_checked;
  int          seed;
  int          n;
  int          hi;
  int          md;
  int          k;
  int          sel;
  logic [15:0] v;
  bit          lo_seen;

  pwmt_core i_dut (.ref_clk(ref_clk), .rst_n(rst_n), .cfg(cfg), .wr(wr),
    .rd_addr(rd_addr), .rd_data(rd_data), .counter_value(counter_value),
    .count_down(count_down), .pwm_out(pwm_out));

  // Free-running 200 MHz clock
  initial begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end

  // ------------------------------------------------------------
  // Tasks and expectations
  // ------------------------------------------------------------
  task automatic chk(input bit ok, input string msg);
    samples_checked++;
    if (!ok) begin
      failures++;
      $display("CHECK FAILED at %0t: %s", $time, msg);
    end
  endtask : chk

  task automatic close_out();
    $display("checks %0d, mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : close_out

  // One edge, then let its updates land before sampling
  task automatic cyc();
    @(posedge ref_clk);
    #1;
  endtask : cyc

  task automatic wr_byte(input logic [2:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    wr <= '{en: 1'b1, addr: a, data: d};
    @(posedge ref_clk);
    wr.en <= 1'b0;
  endtask : wr_byte

  task automatic set_css(input logic [1:0] c);
    @(posedge ref_clk);
    cfg.clock_source_select <= c;
  endtask : set_css

  // Fresh reset so direction and divider start known, then start counting
  task automatic setup(input logic c, input logic [2:0] ps,
                       input logic [15:0] m, input logic [15:0] cv);
    @(posedge ref_clk);
    rst_n <= 1'b0;
    cfg <= '{center_aligned: c, clock_source_select: 2'h0,
             prescale_select: ps};
    repeat (2) @(posedge ref_clk);
    rst_n <= 1'b1;
    wr_byte(PWMT_A_MOD_H, m[15:8]);
    wr_byte(PWMT_A_MOD_L, m[7:0]);
    wr_byte(PWMT_A_CV_H, cv[15:8]);
    wr_byte(PWMT_A_CV_L, cv[7:0]);
    set_css(2'h1);
  endtask : setup

  // Bounded wait for a count and direction; notes any low output seen
  task automatic wait_at(input logic [15:0] val, input logic dn);
    for (int i = 0; i < 2000; i++) begin
      cyc();
      if (pwm_out !== 1'b1) lo_seen = 1'b1;
      if (counter_value === val &&
          (count_down === dn || !cfg.center_aligned)) return;
    end
    chk(1'b0, "count never reached");
    close_out();
  endtask : wait_at

  // Cycles until the count next moves
  task automatic gap(output int c);
    logic [15:0] s;
    s = counter_value;
    for (c = 1; c < 300; c++) begin
      cyc();
      if (counter_value !== s) return;
    end
    chk(1'b0, "count stuck");
    close_out();
  endtask : gap

  task automatic duty(input int len, output int h);
    h = 0;
    repeat (len) begin
      cyc();
      if (pwm_out === 1'b1) h++;
    end
  endtask : duty

  function automatic logic [15:0] exp_cnt(int m, int i);
    int p;
    p = i % (2 * m);
    return 16'((p <= m) ? p : 2 * m - p);
  endfunction : exp_cnt

  // Active cycles per period; in center mode the silicon loses the top two values.
  // Edge mode clears on the edge after the match: counts 0..cv active
  function automatic int exp_duty(bit c, int m, logic [15:0] cv);
    if (cv[15] || cv == 16'h0000) return 0;
    if (!c) return int'(cv) + 1;
    return (int'(cv) >= m - 1) ? 0 : 2 * int'(cv);
  endfunction : exp_duty

  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  initial begin
    seed = 74845;
    failures = 0;
    samples_checked = 0;
    rst_n = 1'b0;
    cfg = '0;
    wr = '0;
    rd_addr = 3'h0;
    repeat (20) cyc();
    chk(counter_value === 16'h0000 && pwm_out === 1'b0 &&
        count_down === 1'b0 && rd_data === 8'h00, "reset state");
    @(posedge ref_clk);
    rst_n <= 1'b1;
    // Counter bytes read back the stopped, cleared count
    for (int a = 0; a < 7; a++) begin
      v = 16'($random(seed));
      wr_byte(3'(a), v[7:0]);
      @(posedge ref_clk);
      rd_addr <= 3'(a);
      cyc();
      chk(rd_data === ((a < 2 || a == 6) ? 8'h00 : v[7:0]),
          "readback");
    end
    for (int p = 0; p < 8; p++) begin
      setup(1'b0, 3'(p), 16'h0100, 16'h0010);
      gap(n);
      gap(n);
      chk(n == (1 << p), "prescale divide");
    end
    setup(1'b0, 3'h0, 16'h0100, 16'h0000);
    for (int s = 1; s < 4; s++) begin
      set_css(2'h0);
      cyc();
      v = counter_value;
      repeat (8) cyc();
      chk(counter_value === v, "stopped count moved");
      set_css(2'(s));
      gap(n);
      chk(n == 1, "restart");
      v = 16'($random(seed));
      repeat (5) cyc();
      wr_byte({2'b00, v[8]}, v[7:0]);
      #1;
      chk(counter_value === 16'h0000, "clear");
    end
    // Divider phase survives stop, prescale change and clear
    setup(1'b0, 3'h2, 16'h0100, 16'h0000);
    k = 1 + (($random(seed) & 255) % 3);
    gap(n);
    repeat (k - 1) @(posedge ref_clk);
    set_css(2'h0);
    @(posedge ref_clk);
    cfg.prescale_select <= 3'h0;
    wr_byte(PWMT_A_CNT_L, 8'h5A);
    @(posedge ref_clk);
    cfg.prescale_select <= 3'h2;
    set_css(2'h1);
    gap(n);
    chk(n + k == 4, "prescaler phase");
    md = 2 + ($random(seed) & 7);
    setup(1'b1, 3'h0, 16'(md), 16'h0000);
    for (int i = 1; i <= 4 * md; i++) begin
      cyc();
      chk(counter_value === exp_cnt(md, i) &&
          count_down === (i % (2 * md) >= md), "center count");
    end
    // Stop at modulo while up; clear keeps the down direction
    setup(1'b1, 3'h0, 16'h0005, 16'h0000);
    wait_at(16'h0004, 1'b0);
    set_css(2'h0);
    wr_byte(PWMT_A_CNT_H, 8'h33);
    set_css(2'h2);
    cyc();
    chk(counter_value === 16'hFFFF, "wrap below zero");
    cyc();
    chk(counter_value === 16'hFFFE, "keeps counting down");
    for (int i = 0; i < 10; i++) begin
      md = 8 + ($random(seed) & 31);
      sel = (i < 8) ? i % 4 : (i - 8) * 3;
      case (sel)
        // Doubled, even values never equal modulo minus one
        0: v = 16'(2 + 2 * (($random(seed) & 255) % (md / 2 - 1)));
        1: v = 16'(md);
        2: v = 16'(md - 1);
        default: v = 16'h8000 | 16'($random(seed));
      endcase
      n = (i < 8) ? 2 * md : md + 1;
      setup(i < 8, 3'h0, 16'(md), v);
      repeat (3 * n) cyc();
      duty(n, hi);
      chk(hi == exp_duty(i < 8, md, v), "duty");
    end
    // Edge mode: a zero-to-nonzero update costs one dead period
    setup(1'b0, 3'h0, 16'd10, 16'h0000);
    repeat (25) cyc();
    wait_at(16'd2, 1'b0);
    wr_byte(PWMT_A_CV_L, 8'h05);
    wait_at(16'd10, 1'b0);
    duty(11, hi);
    chk(hi == 0, "extra idle period");
    duty(11, hi);
    chk(hi == 6, "new duty");
    // Center: zero to nonzero while down, then back to zero while down
    setup(1'b1, 3'h0, 16'd6, 16'h0000);
    repeat (30) cyc();
    wait_at(16'd6, 1'b1);
    wr_byte(PWMT_A_CV_L, 8'h03);
    wait_at(16'd2, 1'b0);
    chk(pwm_out === 1'b1, "active from mid period");
    lo_seen = 1'b0;
    wait_at(16'd5, 1'b1);
    wr_byte(PWMT_A_CV_L, 8'h00);
    wait_at(16'd5, 1'b0);
    chk(pwm_out === 1'b1 && !lo_seen, "one and a half periods");
    wait_at(16'd3, 1'b1);
    chk(pwm_out === 1'b0, "idle after second period");
    // Center: nonzero to zero while up, before the old compare
    setup(1'b1, 3'h0, 16'd6, 16'd4);
    repeat (30) cyc();
    wait_at(16'd0, 1'b0);
    wr_byte(PWMT_A_CV_L, 8'h00);
    lo_seen = 1'b0;
    wait_at(16'd5, 1'b0);
    chk(pwm_out === 1'b1 && !lo_seen, "held to period end");
    wait_at(16'd3, 1'b1);
    chk(pwm_out === 1'b0, "zero duty next period");
    close_out();
  end
endmodule : tb
`default_nettype wire
